// [design/rtt_pkg.sv]
// Contract
// RQ1: Eight-bit up counter, software read/write, overflows once per 256 prescaled counts.
// RQ2: Software picks the start value as 256 minus interval times prescaled clock.
// RQ3: Fast select 0: rate codes 000..111 divide the CPU clock by 256 down to 2.
// RQ4: Fast select 1: rate codes 000..111 divide the oscillator clock by 128 down to 1.
// RQ5: With auto-reload on, overflow copies the reload value into the counter.
// RQ6: PWM enable forces auto-reload; auto-reload bit then picks the overflow boundary.
// RQ7: Tone enable drives tone onto the shared pin and takes the pin from GPIO.
// RQ8: Tone output toggles on every overflow, half the overflow frequency.
// RQ9: Software keeps PWM disabled while it uses the tone output.
// RQ10: Clearing timer enable stops counting and halts tone and PWM outputs.
// RQ11: Software disables and clears before reconfiguring, and enables the timer last.
// RQ12: Prescaler rate comes from mode register bits 6 to 4.
// RQ13: In external clock mode the fast clock select bit is ignored.
// RQ14: Mode register: enable 7, rate 6..4, reload 2, tone 1, PWM 0, reset 0.
// RQ15: Overflow keeps counting and sets the timer interrupt request flag.
// RQ16: With wake enable set, a time-out wakes the system from low-power mode.
// RQ17: Interrupt request stays set until software clears it, whatever the enable.
package rtt_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] ADDR_CLKSEL = 8'hd8;
    localparam logic [7:0] ADDR_MODE = 8'hda;
    localparam logic [7:0] ADDR_COUNT = 8'hdb;
    localparam logic [7:0] ADDR_RELOAD = 8'hcd;
    localparam logic [7:0] ADDR_IRQ = 8'hc8;
    localparam int unsigned MODE_EN_BIT = 7;
    localparam int unsigned MODE_RATE_LSB = 4;
    localparam int unsigned MODE_RATE_MSB = 6;
    localparam int unsigned MODE_ALOAD_BIT = 2;
    localparam int unsigned MODE_TONE_BIT = 1;
    localparam int unsigned MODE_PWM_BIT = 0;
    localparam logic [7:0] MODE_MASK = 8'hf7;
    localparam int unsigned CLKSEL_FAST_BIT = 2;
    localparam int unsigned CLKSEL_WAKE_BIT = 1;
    localparam int unsigned IRQ_EN_BIT = 0;
    localparam int unsigned IRQ_REQ_BIT = 1;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] PWM_HALF_BOUND = 8'h7f;
    localparam logic [7:0] FCPU_MASK = 8'hff;
    localparam logic [7:0] FOSC_MASK = 8'h7f;
    localparam int unsigned FCPU_DIV = 4;
    localparam logic [1:0] FCPU_LAST = 2'(FCPU_DIV - 1);
endpackage

// [design/rtt_presc_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface rtt_presc_if;
    logic en;
    logic fast_sel;
    logic ext_mode;
    logic ext_edge;
    logic [2:0] rate;
    logic tick;
    modport ctl (
        output en,
        output fast_sel,
        output ext_mode,
        output ext_edge,
        output rate,
        input tick
    );
    modport presc (
        input en,
        input fast_sel,
        input ext_mode,
        input ext_edge,
        input rate,
        output tick
    );
endinterface
`default_nettype wire

// [design/rtt_prescaler.sv]
`timescale 1ns/1ns
`default_nettype none
module rtt_prescaler
    import rtt_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Control from the timer.
    rtt_presc_if.presc p
);
    logic [1:0] fdiv_ff;
    logic [1:0] nxt_fdiv;
    logic [7:0] psc_ff;
    logic [7:0] nxt_psc;
    logic fcpu_tick;
    logic src_tick;
    logic [7:0] mask;

    // The CPU clock rate is a free enable; it never stops with the timer.
    always_comb begin
        fcpu_tick = (fdiv_ff == FCPU_LAST);
        nxt_fdiv = fcpu_tick ? 2'h0 : fdiv_ff + 2'h1;
    end

    always_comb begin
        src_tick = p.fast_sel ? 1'b1 : fcpu_tick;
        mask = p.fast_sel ? (FOSC_MASK >> p.rate) : (FCPU_MASK >> p.rate); // [RQ3] [RQ4]
        nxt_psc = psc_ff;
        if (!p.en) begin
            nxt_psc = 8'h00;
        end else if (src_tick && !p.ext_mode) begin
            nxt_psc = psc_ff + 8'h01;
        end
    end

    // External edges count directly, so the fast select has no say there.
    assign p.tick = p.en && (p.ext_mode ? p.ext_edge
                                        : (src_tick && ((psc_ff & mask) == mask))); // [RQ13]

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            fdiv_ff <= 2'h0;
            psc_ff <= 8'h00;
        end else begin
            fdiv_ff <= nxt_fdiv;
            psc_ff <= nxt_psc;
        end
    end

    // Checker: spacing of ticks while the setting is held.
    logic [15:0] gap_ff;
    logic held_ff;
    logic [3:0] cfg_ff;
    logic [15:0] expect_gap;
    always_comb begin
        if (p.fast_sel) begin
            expect_gap = 16'h0080 >> p.rate;
        end else begin
            expect_gap = 16'(32'(16'h0100 >> p.rate) * FCPU_DIV);
        end
    end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            gap_ff <= 16'h0000;
            held_ff <= 1'b0;
            cfg_ff <= 4'h0;
        end else begin
            cfg_ff <= {p.fast_sel, p.rate};
            gap_ff <= p.tick ? 16'h0001 : gap_ff + 16'h0001;
            if (!p.en || p.ext_mode || cfg_ff != {p.fast_sel, p.rate}) begin
                held_ff <= 1'b0;
            end else if (p.tick) begin
                held_ff <= 1'b1;
            end
        end
    end
    a_tick_spacing: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ3] [RQ4]
        (p.tick && held_ff && p.en && !p.ext_mode && cfg_ff == {p.fast_sel, p.rate})
        |-> gap_ff == expect_gap)
        else $error("prescaled tick spacing wrong");
    a_ext_direct: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ13]
        (p.en && p.ext_mode) |-> (p.tick == p.ext_edge))
        else $error("external edge not passed as tick");
endmodule
`default_nettype wire

// [design/rtt_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module rtt_timer
    import rtt_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register port.
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // External clock source.
    input wire logic ext_clk_mode_i,
    input wire logic ext_clk_pin_i,
    // Tone pin and PWM.
    output logic tone_o,
    output logic tone_oe_o,
    output logic gpio_takeover_o,
    output logic pwm_o,
    // Events.
    output logic irq_o,
    output logic irq_flag_o,
    output logic wake_o
);
    rtt_presc_if pif ();

    logic [7:0] mode_ff;
    logic [7:0] nxt_mode;
    logic [7:0] count_ff;
    logic [7:0] nxt_count;
    logic [7:0] reload_ff;
    logic [7:0] nxt_reload;
    logic fast_ff;
    logic nxt_fast;
    logic wake_en_ff;
    logic nxt_wake_en;
    logic ie_ff;
    logic nxt_ie;
    logic req_ff;
    logic nxt_req;
    logic tone_ff;
    logic nxt_tone;
    logic pwm_ff;
    logic nxt_pwm;
    logic wake_ff;
    logic nxt_wake;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;

    logic timer_en;
    logic auto_reload;
    logic tone_en;
    logic pwm_en;
    logic reload_act;
    logic tone_act;
    logic [7:0] bound;
    logic ovf;
    logic wr_mode;
    logic wr_count;
    logic wr_reload;
    logic wr_clksel;
    logic wr_irq;

    always_comb begin
        timer_en = mode_ff[MODE_EN_BIT];
        auto_reload = mode_ff[MODE_ALOAD_BIT];
        tone_en = mode_ff[MODE_TONE_BIT];
        pwm_en = mode_ff[MODE_PWM_BIT];
        reload_act = auto_reload || pwm_en; // [RQ6]
        tone_act = timer_en && tone_en && !pwm_en;
        bound = (pwm_en && auto_reload) ? PWM_HALF_BOUND : COUNT_MAX; // [RQ6]
        ovf = pif.tick && (count_ff == bound);
        wr_mode = wr_i && (addr_i == ADDR_MODE);
        wr_count = wr_i && (addr_i == ADDR_COUNT);
        wr_reload = wr_i && (addr_i == ADDR_RELOAD);
        wr_clksel = wr_i && (addr_i == ADDR_CLKSEL);
        wr_irq = wr_i && (addr_i == ADDR_IRQ);
    end

    // The pin is asynchronous; only the second and third stages feed the edge detect.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= ext_clk_pin_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    assign pif.en = timer_en; // [RQ10]
    assign pif.fast_sel = fast_ff;
    assign pif.ext_mode = ext_clk_mode_i;
    assign pif.ext_edge = sync2_ff && !sync3_ff;
    assign pif.rate = mode_ff[MODE_RATE_MSB:MODE_RATE_LSB]; // [RQ12]

    rtt_prescaler u_presc (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .p(pif.presc)
    );

    // Configuration registers.
    always_comb begin
        nxt_mode = wr_mode ? (wdata_i & MODE_MASK) : mode_ff; // [RQ14]
        nxt_reload = wr_reload ? wdata_i : reload_ff;
        nxt_fast = wr_clksel ? wdata_i[CLKSEL_FAST_BIT] : fast_ff;
        nxt_wake_en = wr_clksel ? wdata_i[CLKSEL_WAKE_BIT] : wake_en_ff;
        nxt_ie = wr_irq ? wdata_i[IRQ_EN_BIT] : ie_ff;
    end

    // Counter; a software write in the same cycle as a tick takes priority.
    always_comb begin
        nxt_count = count_ff;
        if (wr_count) begin
            nxt_count = wdata_i; // [RQ1]
        end else if (pif.tick) begin
            if (ovf) begin
                nxt_count = reload_act ? reload_ff : COUNT_ZERO; // [RQ5] [RQ15]
            end else begin
                nxt_count = count_ff + 8'h01; // [RQ1]
            end
        end
    end

    // Request flag: an overflow in the clearing cycle still sets it.
    always_comb begin
        nxt_req = req_ff;
        if (wr_irq && !wdata_i[IRQ_REQ_BIT]) begin
            nxt_req = 1'b0;
        end
        if (ovf) begin
            nxt_req = 1'b1; // [RQ15] [RQ17]
        end
    end

    // Tone and PWM outputs hold their level while the timer is stopped.
    always_comb begin
        nxt_tone = tone_ff;
        if (tone_act && ovf) begin
            nxt_tone = !tone_ff; // [RQ8]
        end
        if (!pwm_en) begin
            nxt_pwm = 1'b0;
        end else if (timer_en) begin
            nxt_pwm = (nxt_count >= reload_ff);
        end else begin
            nxt_pwm = pwm_ff; // [RQ10]
        end
        nxt_wake = ovf && wake_en_ff; // [RQ16]
    end

    // Read data stands only in the cycle after the strobe.
    always_comb begin
        nxt_rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                ADDR_MODE: nxt_rdata = mode_ff;
                ADDR_COUNT: nxt_rdata = count_ff; // [RQ1]
                ADDR_CLKSEL: begin
                    nxt_rdata[CLKSEL_FAST_BIT] = fast_ff;
                    nxt_rdata[CLKSEL_WAKE_BIT] = wake_en_ff;
                end
                ADDR_IRQ: begin
                    nxt_rdata[IRQ_EN_BIT] = ie_ff;
                    nxt_rdata[IRQ_REQ_BIT] = req_ff;
                end
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mode_ff <= REG_RST;
            count_ff <= REG_RST;
            reload_ff <= REG_RST;
            fast_ff <= 1'b0;
            wake_en_ff <= 1'b0;
            ie_ff <= 1'b0;
            req_ff <= 1'b0;
            tone_ff <= 1'b0;
            pwm_ff <= 1'b0;
            wake_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            mode_ff <= nxt_mode;
            count_ff <= nxt_count;
            reload_ff <= nxt_reload;
            fast_ff <= nxt_fast;
            wake_en_ff <= nxt_wake_en;
            ie_ff <= nxt_ie;
            req_ff <= nxt_req;
            tone_ff <= nxt_tone;
            pwm_ff <= nxt_pwm;
            wake_ff <= nxt_wake;
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_o = rdata_ff;
    assign tone_o = tone_ff;
    assign tone_oe_o = tone_en && !pwm_en; // [RQ7]
    assign gpio_takeover_o = tone_en && !pwm_en; // [RQ7]
    assign pwm_o = pwm_ff;
    assign irq_flag_o = req_ff;
    assign irq_o = req_ff && ie_ff; // [RQ15]
    assign wake_o = wake_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_ovf;
        pif.tick && count_ff == bound && !wr_count;
    endsequence

    a_count_step: assert property ( // [RQ1]
        (pif.tick && !wr_count && count_ff != bound) |=> count_ff == $past(count_ff) + 8'h01)
        else $error("counter did not step by one");
    a_count_wrap: assert property ( // [RQ1]
        (s_ovf ##0 !reload_act) |=> count_ff == COUNT_ZERO)
        else $error("counter did not wrap to zero");
    a_reload_copy: assert property ( // [RQ5]
        (s_ovf ##0 (reload_act && !wr_reload)) |=> count_ff == $past(reload_ff))
        else $error("reload value not copied");
    a_pwm_forces: assert property ( // [RQ6]
        (s_ovf ##0 (pwm_en && !auto_reload && !wr_reload)) |=> count_ff == $past(reload_ff))
        else $error("pwm did not force reload");
    a_tone_toggle: assert property ( // [RQ8]
        (pif.tick && count_ff == bound && tone_act) |=> tone_o != $past(tone_o))
        else $error("tone did not toggle on overflow");
    // The cycle after a mode write is left out: the PWM level registered there still used the old mode.
    a_stop_holds: assert property ( // [RQ10]
        (!timer_en && !wr_count && !wr_mode && !$past(wr_mode))
        |=> $stable(count_ff) && $stable(tone_o) && $stable(pwm_o))
        else $error("stopped timer still moving");
    a_pin_takeover: assert property ( // [RQ7]
        (tone_oe_o == (tone_en && !pwm_en)) && (gpio_takeover_o == tone_oe_o))
        else $error("tone pin not taken over");
    a_req_set: assert property ( // [RQ15]
        (pif.tick && count_ff == bound) |=> irq_flag_o ##1 (irq_flag_o || $past(wr_irq)))
        else $error("overflow did not set request");
    a_req_sticky: assert property ( // [RQ17]
        (irq_flag_o && !wr_irq) |=> irq_flag_o)
        else $error("request flag lost without clear");
    a_wake_pulse: assert property ( // [RQ16]
        (pif.tick && count_ff == bound && wake_en_ff) |=> wake_o ##1 !wake_o || $past(ovf))
        else $error("wake pulse missing");
    a_rate_field: assert property ( // [RQ12]
        $past(wr_mode) |-> pif.rate == 3'($past(wdata_i) >> MODE_RATE_LSB))
        else $error("rate field not taken from mode bits");
endmodule
`default_nettype wire

// [tb/rtt_buzzer.sv]
`timescale 1ns/1ns
`default_nettype none
module rtt_buzzer (
    // Clock.
    input wire logic clk_i,
    // Tone pin as the block presents it.
    input wire logic tone_i,
    input wire logic tone_oe_i,
    // Toggles heard by the load.
    output logic [15:0] edges_o
);
    logic pin_ff = 1'b1;
    logic [15:0] cnt = 16'h0000;
    // The pin has a pull-up, so a released pin reads high, never the last driven level.
    wire logic pin = tone_oe_i ? tone_i : 1'b1;
    assign edges_o = cnt;
    always @(posedge clk_i) begin
        pin_ff <= pin;
        if (tone_oe_i && (pin != pin_ff)) begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// [tb/test_reloadable_8bit_timer_with_tone_out.sv]
`timescale 1ns/1ns
`default_nettype none
module test_reloadable_8bit_timer_with_tone_out;
    import rtt_pkg::*;
    logic clk_i, resetn_i, wr_i, rd_i, ext_clk_mode_i, ext_clk_pin_i;
    logic [7:0] addr_i, wdata_i, rdata_o, rv, m;
    logic tone_o, tone_oe_o, gpio_takeover_o, pwm_o, irq_o, irq_flag_o, wake_o, t1;
    logic [15:0] edges;
    logic [7:0] regs [6];
    int failures, checked;

    rtt_timer u_rtt_timer (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_clk_mode_i(ext_clk_mode_i),
        .ext_clk_pin_i(ext_clk_pin_i), .tone_o(tone_o), .tone_oe_o(tone_oe_o),
        .gpio_takeover_o(gpio_takeover_o), .pwm_o(pwm_o), .irq_o(irq_o), .irq_flag_o(irq_flag_o),
        .wake_o(wake_o));
    rtt_buzzer u_rtt_buzzer (.clk_i(clk_i), .tone_i(tone_o), .tone_oe_i(tone_oe_o), .edges_o(edges));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    // Counts clock cycles up to the next wake pulse; a hang ends the run as a failure.
    task automatic wait_wake(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
            if (n > 20000) begin
                failures++;
                report_and_stop();
            end
        end while (wake_o !== 1'b1);
    endtask

    // Clocks between overflows: prescale period times ticks from start value to boundary.
    function automatic logic [15:0] exp_period(input logic [7:0] md, input logic fast, input logic [7:0] r);
        logic [15:0] tick, ticks;
        tick = fast ? (16'h0080 >> md[6:4]) : 16'((16'h0100 >> md[6:4]) * FCPU_DIV);
        if (md[0] || md[2]) begin
            ticks = ((md[0] && md[2]) ? 16'h0080 : 16'h0100) - {8'h00, r};
        end else begin
            ticks = 16'h0100;
        end
        return tick * ticks;
    endfunction

    task automatic run(input logic [7:0] md, input logic fast, input logic [7:0] r);
        int n;
        logic t0;
        logic [15:0] e0;
        logic drv;
        drv = md[1] && !md[0];
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_CLKSEL, {5'h00, fast, 2'b10});
        wr(ADDR_RELOAD, r);
        wr(ADDR_COUNT, r);
        wr(ADDR_MODE, md | 8'h80);
        wait_wake(n);
        t0 = tone_o;
        e0 = edges;
        wait_wake(n);
        check(16'(n), exp_period(md, fast, r));
        check({15'h0000, tone_o}, {15'h0000, t0 ^ drv});
        check({15'h0000, pwm_o}, {15'h0000, md[0]});
        check(edges - e0, drv ? 16'h0001 : 16'h0000);
        check({14'h0000, tone_oe_o, gpio_takeover_o}, drv ? 16'h0003 : 16'h0000);
    endtask

    initial begin
        {resetn_i, wr_i, rd_i, ext_clk_mode_i, ext_clk_pin_i, addr_i, wdata_i} = '0;
        failures = 0;
        checked = 0;
        regs = '{ADDR_MODE, ADDR_COUNT, ADDR_RELOAD, ADDR_CLKSEL, ADDR_IRQ, 8'h55};
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        void'($urandom(32'h8f9e2e0e));
        wr(8'h55, 8'hff);
        foreach (regs[i]) begin
            rd(regs[i], rv);
            check(16'(rv), 16'h0000);
        end
        wr(ADDR_MODE, 8'h7f);
        rd(ADDR_MODE, rv);
        check(16'(rv), 16'h0077);
        wr(ADDR_RELOAD, 8'hab);
        rd(ADDR_RELOAD, rv);
        check(16'(rv), 16'h0000);
        m = 8'($urandom());
        wr(ADDR_COUNT, m);
        rd(ADDR_COUNT, rv);
        check(16'(rv), 16'(m));
        for (int f = 0; f < 2; f++) begin
            for (int r = 0; r < 8; r++) begin
                run({1'b0, 3'(r), 4'b0110}, f[0], 8'hff);
            end
        end
        // Hand-picked boundaries: start at zero, plain overflow, both PWM boundaries.
        run(8'h76, 1'b1, 8'h00);
        run(8'h70, 1'b1, 8'h33);
        run(8'h71, 1'b1, 8'h10);
        run(8'h75, 1'b1, 8'h7f);
        repeat (6) begin
            rv = 8'($urandom());
            m = {1'b0, 3'($urandom_range(7, 4)), 1'b0, 3'($urandom())};
            run(m, 1'b1, (m[0] && m[2]) ? {1'b0, rv[6:0]} : rv);
        end
        // Every run above overflowed while the interrupt enable stayed clear.
        check({14'h0000, irq_flag_o, irq_o}, 16'h0002);
        wr(ADDR_IRQ, 8'h03);
        #1;
        check({15'h0000, irq_o}, 16'h0001);
        wr(ADDR_MODE, 8'h72);
        rd(ADDR_COUNT, m);
        t1 = tone_o;
        repeat (40) @(posedge clk_i);
        rd(ADDR_COUNT, rv);
        check(16'(rv), 16'(m));
        check({15'h0000, tone_o}, {15'h0000, t1});
        wr(ADDR_IRQ, 8'h01);
        #1;
        check({14'h0000, irq_flag_o, irq_o}, 16'h0000);
        wr(ADDR_COUNT, 8'h10);
        wr(ADDR_CLKSEL, 8'h04);
        ext_clk_mode_i <= 1'b1;
        wr(ADDR_MODE, 8'hf0);
        repeat (5) begin
            repeat (3) @(posedge clk_i);
            ext_clk_pin_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            ext_clk_pin_i <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        rd(ADDR_COUNT, rv);
        check(16'(rv), 16'h0015);
        report_and_stop();
    end
endmodule
`default_nettype wire
